//--- design/tmo_output_prescaler.v
`timescale 1ns/1ps
`default_nettype none
`include "tmo_map.vh"
module tmo_output_prescaler (
   input  wire        sys_clk,
   input  wire        reset_n,
   input  wire        ctrlWrite,
   input  wire [7:0]  ctrlWdata,
   output reg  [7:0]  ctrlRdata_r,
   input  wire        prescWrite,
   input  wire [7:0]  prescWdata,
   output reg  [7:0]  prescRdata_r,
   input  wire        countEnable,
   input  wire [15:0] timerCounterValue,
   input  wire [15:0] compareRegA,
   input  wire [15:0] compareRegB,
   input  wire        extInputA,
   input  wire        extInputB,
   output reg         countTick_r,
   output wire        edgeA_r,
   output wire        edgeB_r,
   output reg         outputFlipflop_r,
   output reg         timerOut_r
);
   reg  [7:0]  ctrl_r;
   reg  [7:0]  presc_r;
   reg  [7:0]  ctrl_nxt;
   reg  [15:0] lastCount_r;
   reg  [2:0]  div_r;
   reg  [2:0]  divLast;
   reg         countTick_nxt;
   reg         outputFlipflop_nxt;
   wire        countMoved;
   wire        matchA;
   wire        matchB;
   wire [1:0]  setReset;
   wire [1:0]  clkSel;

   // the force field is decoded straight from the write data, never from storage;
   // keeping it out of the stored image means a later write of the enable or
   // invert bits cannot replay an old set or clear onto the output flip-flop
   assign setReset = ctrlWdata[`TMO_CTL_SET:`TMO_CTL_RST];
   assign clkSel   = presc_r[`TMO_PRE_CLK_MSB:`TMO_PRE_CLK_LSB];

   // stored control bits; set/reset and one-shot trigger are never stored
   // bit layout of the stored image:
   //   b0 output enable, b1 invert on match a, b4 invert on match b,
   //   b5 one-shot enable (kept for read-back only, no pulse logic behind it)
   // bits 2, 3, 6 and 7 always read zero
   always @* begin
      ctrl_nxt = ctrl_r;
      if (ctrlWrite) begin
         ctrl_nxt = ctrlWdata & 8'h33;
      end
      ctrl_nxt[`TMO_CTL_SET]         = 1'b0;
      ctrl_nxt[`TMO_CTL_RST]         = 1'b0;
      ctrl_nxt[`TMO_CTL_ONESHOT_TRG] = 1'b0;
   end

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= `TMO_CTL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // prescaler configuration; software must stop the timer first, no interlock here
   // a write while running takes effect at once, so the divider phase and the
   // edge history may give one short or extra tick; an interlock was left out
   // to keep the write path a single strobe
   // bits 3:2 are dropped and read back as zero
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         presc_r <= `TMO_PRE_RESET;
      end else if (prescWrite) begin
         presc_r <= prescWdata & 8'hF3;
      end
   end

   // read-back mirrors, one cycle behind the stored value
   // registering the read data keeps every top-level output on a flip-flop;
   // the cost is that software sees a write two edges after its strobe
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlRdata_r  <= 8'h00;
         prescRdata_r <= 8'h00;
      end else begin
         ctrlRdata_r  <= ctrl_r;
         prescRdata_r <= presc_r;
      end
   end

   // edge detectors on the two external inputs
   // each pin is asynchronous, so each detector carries its own two-stage
   // synchroniser; an edge pulse thus appears three edges after the pin moves
   // and pin changes closer than one cycle apart may be merged
   tmo_edge_detect edgeDetA (
      .sys_clk     (sys_clk),
      .reset_n     (reset_n),
      .pinIn       (extInputA),
      .countEnable (countEnable),
      .edgeSel     (presc_r[`TMO_PRE_EDGE_A_MSB:`TMO_PRE_EDGE_A_LSB]),
      .edgePulse_r (edgeA_r)
   );

   tmo_edge_detect edgeDetB (
      .sys_clk     (sys_clk),
      .reset_n     (reset_n),
      .pinIn       (extInputB),
      .countEnable (countEnable),
      .edgeSel     (presc_r[`TMO_PRE_EDGE_B_MSB:`TMO_PRE_EDGE_B_LSB]),
      .edgePulse_r (edgeB_r)
   );

   // divider terminal count for the selected ratio
   // the divider is a free 3-bit counter; a ratio of 2, 4 or 8 fires when the
   // low bits selected by the terminal mask are all ones, so no compare per
   // ratio is needed and the three ratios share one counter
   always @* begin
      divLast = `TMO_DIV8_LAST;
      case (clkSel)
         `TMO_CLK_DIV2: divLast = `TMO_DIV2_LAST;
         `TMO_CLK_DIV4: divLast = `TMO_DIV4_LAST;
         default:       divLast = `TMO_DIV8_LAST;
      endcase
   end

   // count clock: divided system clock or edge A; divider is cleared to zero while stopped
   // with the edge-a clock selected the same edge must not also clear the
   // counter or trigger a capture; nothing here guards against that
   always @* begin
      if (clkSel == `TMO_CLK_EDGE_A) begin
         countTick_nxt = edgeA_r;
      end else begin
         countTick_nxt = countEnable && ((div_r & divLast) == divLast);
      end
   end

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_r       <= 3'h0;
         countTick_r <= 1'b0;
      end else begin
         div_r       <= countEnable ? div_r + 3'h1 : 3'h0;
         countTick_r <= countTick_nxt;
      end
   end

   // a match counts once, when the counter arrives at the compare value
   // the counter may stay on one value for several system clocks between
   // count ticks; comparing against the previous value keeps a long stay
   // on the compare value from toggling the flip-flop on every cycle
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         lastCount_r <= 16'h0000;
      end else begin
         lastCount_r <= timerCounterValue;
      end
   end

   assign countMoved = (timerCounterValue != lastCount_r) && countEnable;
   assign matchA     = countMoved && (timerCounterValue == compareRegA) && ctrl_r[`TMO_CTL_INV_A];
   assign matchB     = countMoved && (timerCounterValue == compareRegB) && ctrl_r[`TMO_CTL_INV_B];

   // software force wins over a match; the prohibited code 11 changes nothing
   // a match on a and b in the same cycle gives a single toggle, not two
   always @* begin
      outputFlipflop_nxt = outputFlipflop_r;
      if (ctrlWrite && setReset == `TMO_SR_SET) begin
         outputFlipflop_nxt = 1'b1;
      end else if (ctrlWrite && setReset == `TMO_SR_RESET) begin
         outputFlipflop_nxt = 1'b0;
      end else if (matchA || matchB) begin
         outputFlipflop_nxt = ~outputFlipflop_r;
      end
   end

   // pin is the flip-flop gated by the enable; the enable used is the one being written
   // with the enable low the pin sits at zero whatever the flip-flop holds,
   // and the flip-flop keeps toggling so the pin resumes in phase
   // a shared pin used as an edge input must not also be used as this output
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         outputFlipflop_r <= 1'b0;
         timerOut_r       <= 1'b0;
      end else begin
         outputFlipflop_r <= outputFlipflop_nxt;
         timerOut_r       <= outputFlipflop_nxt & ctrl_nxt[`TMO_CTL_OUT_EN];
      end
   end
endmodule
`default_nettype wire

//--- design/tmo_map.vh
`ifndef TMO_MAP_VH
`define TMO_MAP_VH
// output control register fields
`define TMO_CTL_OUT_EN      0
`define TMO_CTL_INV_A       1
`define TMO_CTL_RST         2
`define TMO_CTL_SET         3
`define TMO_CTL_INV_B       4
`define TMO_CTL_ONESHOT_EN  5
`define TMO_CTL_ONESHOT_TRG 6
`define TMO_CTL_RESET       8'h00
// prescaler config fields
`define TMO_PRE_CLK_LSB     0
`define TMO_PRE_CLK_MSB     1
`define TMO_PRE_EDGE_A_LSB  4
`define TMO_PRE_EDGE_A_MSB  5
`define TMO_PRE_EDGE_B_LSB  6
`define TMO_PRE_EDGE_B_MSB  7
`define TMO_PRE_RESET       8'h00
// count clock selections
`define TMO_CLK_DIV2        2'h0
`define TMO_CLK_DIV4        2'h1
`define TMO_CLK_DIV8        2'h2
`define TMO_CLK_EDGE_A      2'h3
// divider terminal counts
`define TMO_DIV2_LAST       3'h1
`define TMO_DIV4_LAST       3'h3
`define TMO_DIV8_LAST       3'h7
// edge selection codes; 2'h2 is prohibited
`define TMO_EDGE_FALL       2'h0
`define TMO_EDGE_RISE       2'h1
`define TMO_EDGE_BAD        2'h2
`define TMO_EDGE_BOTH       2'h3
// set/reset field codes
`define TMO_SR_SET          2'h2
`define TMO_SR_RESET        2'h1
`endif

//--- design/tmo_edge_detect.v
`timescale 1ns/1ps
`default_nettype none
`include "tmo_map.vh"
module tmo_edge_detect (
   input  wire       sys_clk,
   input  wire       reset_n,
   input  wire       pinIn,
   input  wire       countEnable,
   input  wire [1:0] edgeSel,
   output reg        edgePulse_r
);
   reg  syncFirst_r;
   reg  syncLevel_r;
   reg  prevLevel_r;
   reg  armed_r;
   wire rise;
   wire fall;
   reg  edgePulse_nxt;

   // two-stage synchroniser, the first stage feeds only the second
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         syncFirst_r <= 1'b0;
         syncLevel_r <= 1'b0;
      end else begin
         syncFirst_r <= pinIn;
         syncLevel_r <= syncFirst_r;
      end
   end

   // history starts low after reset so a high pin looks like a rise on first enable;
   // once armed it keeps tracking while stopped, so a restart sees no false rise
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         prevLevel_r <= 1'b0;
         armed_r     <= 1'b0;
      end else if (countEnable || armed_r) begin
         prevLevel_r <= syncLevel_r;
         armed_r     <= 1'b1;
      end
   end

   assign rise = syncLevel_r & ~prevLevel_r;
   assign fall = ~syncLevel_r & prevLevel_r;

   // valid edge selection; the prohibited code yields no edge
   always @* begin
      edgePulse_nxt = 1'b0;
      case (edgeSel)
         `TMO_EDGE_FALL: edgePulse_nxt = fall;
         `TMO_EDGE_RISE: edgePulse_nxt = rise;
         `TMO_EDGE_BOTH: edgePulse_nxt = rise | fall;
         default:        edgePulse_nxt = 1'b0;
      endcase
      edgePulse_nxt = edgePulse_nxt & countEnable;
   end

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         edgePulse_r <= 1'b0;
      end else begin
         edgePulse_r <= edgePulse_nxt;
      end
   end
endmodule
`default_nettype wire

//--- test/tmo_output_prescaler_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tmo_output_prescaler_monitor (
   input wire logic       sys_clk,
   input wire logic       reset_n,
   input wire logic       ctrlWrite,
   input wire logic [7:0] ctrlWdata,
   input wire logic [7:0] ctrlRdata_r,
   input wire logic [7:0] prescRdata_r,
   input wire logic       countEnable,
   input wire logic       countTick_r,
   input wire logic       edgeA_r,
   input wire logic       edgeB_r,
   input wire logic       outputFlipflop_r,
   input wire logic       timerOut_r
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // force writes, one sequence per code
   sequence s_set;
      ctrlWrite && ctrlWdata[3:2] == 2'h2;
   endsequence
   sequence s_clr;
      ctrlWrite && ctrlWdata[3:2] == 2'h1;
   endsequence
   property p_set; s_set |=> outputFlipflop_r; endproperty
   property p_clr; s_clr |=> !outputFlipflop_r; endproperty
   property p_oe; ctrlWrite && !ctrlWdata[0] |=> !timerOut_r; endproperty
   property p_pin; timerOut_r |-> outputFlipflop_r; endproperty
   property p_rdz; ctrlRdata_r[3:2] == 2'h0; endproperty
   property p_rst; $rose(reset_n) |-> prescRdata_r == 8'h00 && ctrlRdata_r == 8'h00; endproperty
   property p_stop; !countEnable [*2] |-> !edgeA_r && !edgeB_r; endproperty
   property p_ff; $changed(outputFlipflop_r) |-> $past(ctrlWrite) || $past(countEnable); endproperty
   property p_tick; prescRdata_r[1:0] == 2'h3 && edgeA_r |=> countTick_r; endproperty
   a_set: assert property (p_set) else $error("force one lost");
   a_clr: assert property (p_clr) else $error("force zero lost");
   a_oe: assert property (p_oe) else $error("pin not held low");
   a_pin: assert property (p_pin) else $error("pin differs from flip-flop");
   a_rdz: assert property (p_rdz) else $error("force bits read back");
   a_rst: assert property (p_rst) else $error("registers not cleared");
   a_stop: assert property (p_stop) else $error("edge while stopped");
   a_ff: assert property (p_ff) else $error("flip-flop moved uncaused");
   a_tick: assert property (p_tick) else $error("edge clock tick missing");
endmodule
`default_nettype wire

//--- test/tmo_ext_pins.sv
`timescale 1ns/1ps
`default_nettype none
module tmo_ext_pins (
   input  wire logic       sys_clk,
   input  wire logic [1:0] pins,
   output var logic        extInputA,
   output var logic        extInputB
);
   // shared pins act as inputs only, never driven back as outputs
   initial begin
      extInputA = 1'b0;
      extInputB = 1'b0;
   end
   // levels move just after an edge, unrelated to the sync stage
   always @(posedge sys_clk) begin
      extInputA <= #1 pins[1];
      extInputB <= #1 pins[0];
   end
endmodule
`default_nettype wire

//--- test/tmo_output_prescaler_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tmo_output_prescaler_tb_top;
   logic sys_clk = 0, reset_n = 0, ctrlWrite = 0, prescWrite = 0, countEnable = 0;
   logic [7:0] ctrlWdata = 8'h00, prescWdata = 8'h00, ctrlRdata_r, prescRdata_r;
   logic [15:0] timerCounterValue = 16'h0000, compareRegA = 16'h0005, compareRegB = 16'h0007;
   logic [1:0] pins = 2'h0;
   logic extInputA, extInputB, countTick_r, edgeA_r, edgeB_r, outputFlipflop_r, timerOut_r;
   int errors = 0, cmp_count = 0, nA, nB, nT;
   int expN[4] = '{1, 1, 2, 0};
   logic [1:0] codes[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   always #2 sys_clk = ~sys_clk;
   tmo_ext_pins i_pins (.sys_clk, .pins, .extInputA, .extInputB);
   tmo_output_prescaler i_dut (.sys_clk, .reset_n, .ctrlWrite, .ctrlWdata, .ctrlRdata_r, .prescWrite,
      .prescWdata, .prescRdata_r, .countEnable, .timerCounterValue, .compareRegA, .compareRegB,
      .extInputA, .extInputB, .countTick_r, .edgeA_r, .edgeB_r, .outputFlipflop_r, .timerOut_r);
   // pulse counters see pre-edge values, so no race with the design
   always @(posedge sys_clk) begin
      nA += edgeA_r;
      nB += edgeB_r;
      nT += countTick_r;
   end
   task automatic chk(input logic [7:0] exp, input logic [7:0] act);
      cmp_count++;
      if (act !== exp) begin
         errors++;
         $display("[FAIL] %0t exp %h got %h", $time, exp, act);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // one-cycle strobe; c picks control or prescaler
   task automatic wr(input logic c, input logic [7:0] d);
      ctrlWrite = c;
      prescWrite = !c;
      ctrlWdata = d;
      prescWdata = d;
      tick(1);
      ctrlWrite = 0;
      prescWrite = 0;
      // one idle edge so a following call never re-raises a strobe in the same step
      tick(1);
   endtask
   task automatic end_of_test;
      $display("errors %0d cmp_count %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // run is about 370 cycles; the limit leaves ample margin
   initial begin
      #40000;
      errors++;
      end_of_test;
   end
   initial begin
      tick(6);
      reset_n = 1;
      tick(1);
      chk(8'h00, ctrlRdata_r);
      chk(8'h00, prescRdata_r);
      pins = 2'h3;
      wr(0, 8'h50);
      tick(4);
      nA = 0;
      nB = 0;
      countEnable = 1;
      tick(3);
      chk(8'h01, nA[7:0]);
      chk(8'h01, nB[7:0]);
      countEnable = 0;
      tick(3);
      countEnable = 1;
      nA = 0;
      nB = 0;
      tick(4);
      chk(8'h00, nA[7:0] | nB[7:0]);
      wr(1, 8'h09);
      chk(8'h03, {6'h00, outputFlipflop_r, timerOut_r});
      tick(1);
      chk(8'h01, ctrlRdata_r);
      wr(1, 8'h08);
      chk(8'h02, {6'h00, outputFlipflop_r, timerOut_r});
      wr(1, 8'h0C);
      chk(8'h02, {6'h00, outputFlipflop_r, timerOut_r});
      wr(1, 8'h05);
      chk(8'h00, {6'h00, outputFlipflop_r, timerOut_r});
      wr(1, 8'h03);
      timerCounterValue = 16'h0005;
      tick(1);
      chk(8'h03, {6'h00, outputFlipflop_r, timerOut_r});
      tick(2);
      chk(8'h03, {6'h00, outputFlipflop_r, timerOut_r});
      wr(1, 8'h01);
      timerCounterValue = 16'h0004;
      tick(1);
      timerCounterValue = 16'h0005;
      tick(2);
      chk(8'h03, {6'h00, outputFlipflop_r, timerOut_r});
      wr(1, 8'h11);
      timerCounterValue = 16'h0007;
      tick(1);
      chk(8'h00, {6'h00, outputFlipflop_r, timerOut_r});
      // edge-A clock and edge codes; config only written while stopped
      for (int i = 0; i < 4; i++) begin
         countEnable = 0;
         pins = 2'h0;
         wr(0, {codes[i], codes[i], 4'h3});
         tick(4);
         countEnable = 1;
         tick(2);
         nA = 0;
         nB = 0;
         nT = 0;
         pins = 2'h3;
         tick(6);
         pins = 2'h0;
         tick(8);
         chk(expN[i][7:0], nA[7:0]);
         chk(expN[i][7:0], nB[7:0]);
         chk(expN[i][7:0], nT[7:0]);
      end
      for (int d = 0; d < 3; d++) begin
         countEnable = 0;
         wr(0, {6'h00, d[1:0]});
         tick(2);
         countEnable = 1;
         tick(10);
         nT = 0;
         tick(64);
         chk(8'(64 >> (d + 1)), nT[7:0]);
      end
      end_of_test;
   end
endmodule
bind tmo_output_prescaler tmo_output_prescaler_monitor i_mon (.sys_clk, .reset_n, .ctrlWrite, .ctrlWdata,
   .ctrlRdata_r, .prescRdata_r, .countEnable, .countTick_r, .edgeA_r, .edgeB_r, .outputFlipflop_r, .timerOut_r);
`default_nettype wire
